// ==== rtl/ser_pkg.sv ====
package ser_pkg;
    // Channel count and the diagnostic position of channel 0
    localparam int unsigned       NUM_CH         = 14;
    localparam logic [3:0]        DIAG_BASE_POS  = 4'h2;

    // Clock and deglitch timing
    localparam int unsigned       CLK_PERIOD_NS  = 25;
    localparam int unsigned       DG_INT_MIN_NS  = 15000;
    localparam int unsigned       DG_REG_MIN_NS  = 10000;
    localparam int unsigned       DG_INT_CYCLES  = (DG_INT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned       DG_REG_CYCLES  = (DG_REG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Channel groups, one bit per channel
    localparam logic [13:0]       CH_INTERNAL    = 14'h003f;
    localparam logic [13:0]       CH_UV_INVERTED = 14'h1549;
    localparam logic [13:0]       CH_STANDBY     = 14'h0037;
    localparam logic [13:0]       CH_RESET       = 14'h0400;
    localparam logic [13:0]       CH_DRIVE       = 14'h0a00;
    localparam int unsigned       CH_CORE_UV     = 12;
    localparam int unsigned       CH_CORE_OV     = 13;

    // Register byte offsets
    localparam logic [7:0]        OFS_CTRL       = 8'h00;
    localparam logic [7:0]        OFS_DIAG_SEL   = 8'h04;
    localparam logic [7:0]        OFS_FLAGS      = 8'h08;
    localparam logic [7:0]        OFS_IRQ_STAT   = 8'h0c;
    localparam logic [7:0]        OFS_IRQ_MASK   = 8'h10;
    localparam logic [7:0]        OFS_REACTION   = 8'h14;

    // Field positions and values after reset
    localparam int unsigned       CTRL_UNMASK_BIT = 0;
    localparam logic              RST_UNMASK      = 1'h0;
    localparam logic [3:0]        RST_DIAG_SEL    = 4'h2;
    localparam logic [13:0]       RST_IRQ_MASK    = 14'h0000;

    // Bus answers
    localparam logic [1:0]        RESP_OKAY      = 2'h0;
    localparam logic [1:0]        RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        SER_KEEP,
        SER_RESET,
        SER_STANDBY
    } ser_state_t;
endpackage

// ==== rtl/ser_reg_if.sv ====
interface ser_reg_if #(parameter int unsigned ADDR_W = 8);
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_ok;
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              rd_ok;

    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  input  wr_ok, rd_data, rd_ok);
    modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_ok, rd_data, rd_ok);
endinterface

// ==== rtl/ser_deglitch.sv ====
module ser_deglitch #(
    parameter int unsigned CYCLES = 400
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // Comparator fault level and qualified flag
    input  wire logic fault,
    output logic      flag_q
);
    localparam int unsigned CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= '0;
            flag_q <= 1'b0;
        end else if (ce) begin
            if (!fault) begin
                cnt_q  <= '0;
                flag_q <= 1'b0;
            end else if (!flag_q) begin
                if (cnt_q == CNT_LAST) begin
                    flag_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + CNT_W'(1);
                end
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    dg_restart_a: assert property (ce && !fault |=> cnt_q == '0 && !flag_q)
        else $error("deglitch count not restarted");
    dg_expiry_a: assert property (ce && fault && !flag_q && cnt_q == CNT_LAST |=> flag_q)
        else $error("flag not set at expiry");
    dg_early_a: assert property ($rose(flag_q) |-> $past(cnt_q) == CNT_LAST && $past(fault))
        else $error("flag set before full delay");
endmodule // ser_deglitch

// ==== rtl/ser_axil.sv ====
module ser_axil #(
    parameter int unsigned ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // Write channels
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    // Read channels
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    // Register side
    ser_reg_if.bus                 rif
);
    logic aw_hold_q;
    logic w_hold_q;

    assign rif.wr_en   = ce && aw_hold_q && w_hold_q && !s_bvalid;
    assign rif.rd_en   = ce && s_arvalid && s_arready;
    assign rif.rd_addr = s_araddr;

    ////////////////////////////////////////////////////////////////////////////////
    // Write path: address and data taken in either order, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_awready    <= 1'b1;
            s_wready     <= 1'b1;
            s_bvalid     <= 1'b0;
            s_bresp      <= ser_pkg::RESP_OKAY;
            rif.wr_addr  <= '0;
            rif.wr_data  <= '0;
            rif.wr_strb  <= '0;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_hold_q   <= 1'b1;
                s_awready   <= 1'b0;
                rif.wr_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_hold_q    <= 1'b1;
                s_wready    <= 1'b0;
                rif.wr_data <= s_wdata;
                rif.wr_strb <= s_wstrb;
            end
            if (rif.wr_en) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= rif.wr_ok ? ser_pkg::RESP_OKAY : ser_pkg::RESP_SLVERR;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path: data captured on the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= '0;
            s_rresp   <= ser_pkg::RESP_OKAY;
        end else if (ce) begin
            if (rif.rd_en) begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rdata   <= rif.rd_data;
                s_rresp   <= rif.rd_ok ? ser_pkg::RESP_OKAY : ser_pkg::RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end
endmodule // ser_axil

// ==== rtl/ser_top.sv ====
// Notes on behaviour
// - Analog supply undervoltage, deglitched, forces reset low, drive low, standby.
// - Reference high mismatch, deglitched, forces reset low, drive low, standby.
// - Reference low mismatch, deglitched, forces reset low, drive low, standby.
// - Either charge pump overvoltage, deglitched, forces reset low, drive low, standby.
// - Pump12 undervoltage only sets its flag; outputs and state unchanged.
// - Preregulator under or overvoltage only sets its flag after deglitch.
// - Transceiver rail undervoltage only sets its flag.
// - Transceiver or I/O rail overvoltage drives only the drive output low.
// - I/O rail undervoltage forces reset low, drive low, reset state.
// - Core undervoltage acts only when unmask bit is 1: reset low, drive low, reset state.
// - Core overvoltage drives drive output low only when unmask bit is 1.
// - Faults qualify 15 us for internal supplies, 10 us for regulator rails.
// - Each flag visible on diagnostic mux positions 2 to 15, undervoltage inverted.
module ser_top #(
    parameter int unsigned ADDR_W = 8
) (
    // Clock, reset, enable
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // Comparator outputs
    input  wire logic              analog_supply_uv_n,
    input  wire logic              ref_high_mismatch,
    input  wire logic              ref_low_mismatch,
    input  wire logic              pump12_uv_n,
    input  wire logic              pump12_ov,
    input  wire logic              pump17_ov,
    input  wire logic              prereg_uv_n,
    input  wire logic              prereg_ov,
    input  wire logic              xcvr_rail_uv_n,
    input  wire logic              xcvr_rail_ov,
    input  wire logic              io_rail_uv_n,
    input  wire logic              io_rail_ov,
    input  wire logic              core_rail_uv_n,
    input  wire logic              core_rail_ov,
    // Reactions
    output logic                   mcu_reset_n,
    output logic                   power_stage_enable,
    output ser_pkg::ser_state_t    state_request,
    output logic                   diag_mux,
    output logic                   irq,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready
);
    localparam int unsigned N = ser_pkg::NUM_CH;

    logic [N-1:0]        raw;
    logic [N-1:0]        fault;
    logic [N-1:0]        flag;
    logic [N-1:0]        flag_prev_q;
    logic [N-1:0]        irq_stat_q;
    logic [N-1:0]        irq_stat_d;
    logic [N-1:0]        irq_mask_q;
    logic                core_monitor_unmask_q;
    logic [3:0]          diag_sel_q;
    logic                go_standby;
    logic                go_reset;
    logic                go_drive;
    logic [N-1:0]        diag_view;
    logic [3:0]          diag_idx;
    logic                wr_ctrl;
    logic                wr_diag;
    logic                wr_mask;
    logic                rd_stat;

    ser_reg_if #(.ADDR_W(ADDR_W)) rif ();

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator inputs, one per diagnostic position
    assign raw = {core_rail_ov, core_rail_uv_n, io_rail_ov, io_rail_uv_n,
                  xcvr_rail_ov, xcvr_rail_uv_n, prereg_ov, prereg_uv_n,
                  pump17_ov, pump12_ov, pump12_uv_n, ref_low_mismatch,
                  ref_high_mismatch, analog_supply_uv_n};

    // Undervoltage comparators are low while the fault is present
    assign fault = raw ^ ser_pkg::CH_UV_INVERTED;

    for (genvar i = 0; i < N; i++) begin : g_ch
        ser_deglitch #(
            .CYCLES (ser_pkg::CH_INTERNAL[i] ? ser_pkg::DG_INT_CYCLES : ser_pkg::DG_REG_CYCLES)
        ) u_dg (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ce      (ce),
            .fault   (fault[i]),
            .flag_q  (flag[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reaction classes
    assign go_standby = |(flag & ser_pkg::CH_STANDBY);
    assign go_reset   = |(flag & ser_pkg::CH_RESET)
                      || (flag[ser_pkg::CH_CORE_UV] && core_monitor_unmask_q);
    assign go_drive   = |(flag & ser_pkg::CH_DRIVE)
                      || (flag[ser_pkg::CH_CORE_OV] && core_monitor_unmask_q);

    // Pump12 undervoltage, preregulator and transceiver undervoltage sit in no class
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mcu_reset_n        <= 1'b0;
            power_stage_enable <= 1'b0;
            state_request      <= ser_pkg::SER_KEEP;
        end else if (ce) begin
            mcu_reset_n        <= !(go_standby || go_reset);
            power_stage_enable <= !(go_standby || go_reset || go_drive);
            if (go_standby) begin
                state_request <= ser_pkg::SER_STANDBY;
            end else if (go_reset) begin
                state_request <= ser_pkg::SER_RESET;
            end else begin
                state_request <= ser_pkg::SER_KEEP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Diagnostic mux, group 1 positions 2 to 15
    assign diag_view = flag ^ ser_pkg::CH_UV_INVERTED;
    assign diag_idx  = diag_sel_q - ser_pkg::DIAG_BASE_POS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_mux <= 1'b0;
        end else if (ce) begin
            // Positions 0 and 1 belong to other blocks and read low here
            diag_mux <= (diag_sel_q >= ser_pkg::DIAG_BASE_POS) && diag_view[diag_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus
    ser_axil #(.ADDR_W(ADDR_W)) u_axil (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .rif       (rif.bus)
    );

    assign wr_ctrl = rif.wr_en && rif.wr_addr == ADDR_W'(ser_pkg::OFS_CTRL);
    assign wr_diag = rif.wr_en && rif.wr_addr == ADDR_W'(ser_pkg::OFS_DIAG_SEL);
    assign wr_mask = rif.wr_en && rif.wr_addr == ADDR_W'(ser_pkg::OFS_IRQ_MASK);
    assign rd_stat = rif.rd_en && rif.rd_addr == ADDR_W'(ser_pkg::OFS_IRQ_STAT);

    // Read-only registers accept writes as no-ops so software scans stay quiet
    always_comb begin
        rif.wr_ok = 1'b1;
        case (rif.wr_addr)
            ADDR_W'(ser_pkg::OFS_CTRL),
            ADDR_W'(ser_pkg::OFS_DIAG_SEL),
            ADDR_W'(ser_pkg::OFS_FLAGS),
            ADDR_W'(ser_pkg::OFS_IRQ_STAT),
            ADDR_W'(ser_pkg::OFS_IRQ_MASK),
            ADDR_W'(ser_pkg::OFS_REACTION): rif.wr_ok = 1'b1;
            default:                        rif.wr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rif.rd_data = '0;
        rif.rd_ok   = 1'b1;
        case (rif.rd_addr)
            ADDR_W'(ser_pkg::OFS_CTRL):     rif.rd_data[ser_pkg::CTRL_UNMASK_BIT] = core_monitor_unmask_q;
            ADDR_W'(ser_pkg::OFS_DIAG_SEL): rif.rd_data[3:0] = diag_sel_q;
            ADDR_W'(ser_pkg::OFS_FLAGS):    rif.rd_data[N-1:0] = flag;
            ADDR_W'(ser_pkg::OFS_IRQ_STAT): rif.rd_data[N-1:0] = irq_stat_q;
            ADDR_W'(ser_pkg::OFS_IRQ_MASK): rif.rd_data[N-1:0] = irq_mask_q;
            ADDR_W'(ser_pkg::OFS_REACTION): rif.rd_data[3:0] = {state_request, power_stage_enable, mcu_reset_n};
            default:                        rif.rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_monitor_unmask_q <= ser_pkg::RST_UNMASK;
            diag_sel_q            <= ser_pkg::RST_DIAG_SEL;
            irq_mask_q            <= ser_pkg::RST_IRQ_MASK;
        end else if (ce) begin
            if (wr_ctrl && rif.wr_strb[0]) begin
                core_monitor_unmask_q <= rif.wr_data[ser_pkg::CTRL_UNMASK_BIT];
            end
            if (wr_diag && rif.wr_strb[0]) begin
                diag_sel_q <= rif.wr_data[3:0];
            end
            if (wr_mask && rif.wr_strb[0]) begin
                irq_mask_q[7:0] <= rif.wr_data[7:0];
            end
            if (wr_mask && rif.wr_strb[1]) begin
                irq_mask_q[N-1:8] <= rif.wr_data[N-1:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky flag events; a new event outranks the clearing read
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (rd_stat) begin
            irq_stat_d = '0;
        end
        irq_stat_d = irq_stat_d | (flag & ~flag_prev_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_prev_q <= '0;
            irq_stat_q  <= '0;
            irq         <= 1'b0;
        end else if (ce) begin
            flag_prev_q <= flag;
            irq_stat_q  <= irq_stat_d;
            irq         <= |(irq_stat_d & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence standby_cause_s;
        ce && go_standby;
    endsequence

    sequence standby_held_s;
        !mcu_reset_n && !power_stage_enable && state_request == ser_pkg::SER_STANDBY;
    endsequence

    standby_reaction_a: assert property (standby_cause_s |=> standby_held_s)
        else $error("standby reaction missing");
    ref_mismatch_a: assert property (ce && (flag[1] || flag[2]) |=> state_request == ser_pkg::SER_STANDBY)
        else $error("reference mismatch did not request standby");
    pump_ov_a: assert property (ce && (flag[4] || flag[5]) |=> !mcu_reset_n && !power_stage_enable)
        else $error("pump overvoltage did not force outputs low");
    silent_flags_a: assert property (ce && (flag & ~14'h01c8) == '0 |=> mcu_reset_n && power_stage_enable)
        else $error("silent flag changed reaction");
    drive_only_a: assert property (ce && (flag & ~ser_pkg::CH_DRIVE) == '0 && (flag[9] || flag[11])
                                   |=> mcu_reset_n && !power_stage_enable
                                       && state_request == ser_pkg::SER_KEEP)
        else $error("drive-only reaction wrong");
    io_uv_reset_a: assert property (ce && flag[10] && !go_standby |=> state_request == ser_pkg::SER_RESET
                                    && !mcu_reset_n)
        else $error("io undervoltage did not request reset");
    core_masked_a: assert property (ce && !core_monitor_unmask_q && (flag & ~14'h3000) == '0
                                    |=> mcu_reset_n && power_stage_enable)
        else $error("masked core fault changed outputs");
    core_ov_unmask_a: assert property (ce && core_monitor_unmask_q && flag[13] |=> !power_stage_enable)
        else $error("unmasked core overvoltage ignored");
    diag_invert_a: assert property (ce && diag_sel_q == 4'h2 |=> diag_mux == !$past(flag[0]))
        else $error("diag mux view of position 2 wrong");
    worst_wins_a: assert property (ce && go_standby && go_reset |=> state_request == ser_pkg::SER_STANDBY)
        else $error("standby did not outrank reset");
endmodule // ser_top

// ==== dv/ser_mcu_model.sv ====
module ser_mcu_model (
    // Clock
    input  wire logic  aclk,
    // Observed pins
    input  wire logic  mcu_reset_n,
    input  wire logic  power_stage_enable,
    // Falling-edge tallies
    output int         rcnt,
    output int         dcnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic r_q = 1'h0;
    logic d_q = 1'h0;
    initial {rcnt, dcnt} = '0;
    // Counts falls only, so unknowns at start never add
    always @(posedge aclk) begin
        if (r_q === 1'h1 && mcu_reset_n === 1'h0) rcnt <= rcnt + 1;
        if (d_q === 1'h1 && power_stage_enable === 1'h0) dcnt <= dcnt + 1;
        r_q <= mcu_reset_n;
        d_q <= power_stage_enable;
    end
endmodule // ser_mcu_model

// ==== dv/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define RX {state_request, power_stage_enable, mcu_reset_n}
    logic aclk = 1'h0, aresetn = 1'h0, s_awvalid = 1'h0, s_wvalid = 1'h0, s_arvalid = 1'h0, ce = 1'h1;
    logic [13:0] flt = '0;
    logic [7:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata, d;
    logic [1:0] s_bresp, s_rresp, r;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mcu_reset_n, power_stage_enable, diag_mux, irq;
    ser_pkg::ser_state_t state_request;
    int rcnt, dcnt, n_mismatch = 0, samples_checked = 0;
    localparam logic [13:0] UVM = 14'h1549;
    localparam int CLS[14] = '{3, 3, 3, 0, 3, 3, 0, 0, 0, 1, 2, 1, 0, 0};
    always #12.5 aclk = ~aclk;
    ser_top i_dut (.aclk, .aresetn, .ce,
        .analog_supply_uv_n(~flt[0]), .ref_high_mismatch(flt[1]), .ref_low_mismatch(flt[2]),
        .pump12_uv_n(~flt[3]), .pump12_ov(flt[4]), .pump17_ov(flt[5]), .prereg_uv_n(~flt[6]),
        .prereg_ov(flt[7]), .xcvr_rail_uv_n(~flt[8]), .xcvr_rail_ov(flt[9]), .io_rail_uv_n(~flt[10]),
        .io_rail_ov(flt[11]), .core_rail_uv_n(~flt[12]), .core_rail_ov(flt[13]),
        .mcu_reset_n, .power_stage_enable, .state_request, .diag_mux, .irq,
        .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready(1'h1), .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
        .s_rready(1'h1));
    ser_mcu_model i_mcu (.aclk, .mcu_reset_n, .power_stage_enable, .rcnt, .dcnt);
    ////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_awaddr <= a;
        s_wdata <= v;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_awready === 1'h1) s_awvalid <= 1'h0;
            if (s_wready === 1'h1) s_wvalid <= 1'h0;
            if (s_bvalid === 1'h1) break;
        end
        r = s_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_arready === 1'h1) s_arvalid <= 1'h0;
            if (s_rvalid === 1'h1) break;
        end
        d = s_rdata;
        r = s_rresp;
    endtask
    function automatic logic [3:0] rx(input int c);
        case (c)
            0: return {ser_pkg::SER_KEEP, 2'h3};
            1: return {ser_pkg::SER_KEEP, 2'h1};
            2: return {ser_pkg::SER_RESET, 2'h0};
            default: return {ser_pkg::SER_STANDBY, 2'h0};
        endcase
    endfunction
    // One fault on one channel: timing, reaction, view, flags, events
    task automatic run_ch(input int i, input int c);
        wr(ser_pkg::OFS_DIAG_SEL, 32'(i + 2));
        cyc(2);
        `CHK(diag_mux, UVM[i])
        flt <= 14'h1 << i;
        // Flag may set at the full count at the earliest, outputs follow one edge later
        cyc(i < 6 ? 601 : 401);
        `CHK(`RX, rx(0))
        cyc(4);
        `CHK(`RX, rx(c))
        `CHK(diag_mux, ~UVM[i])
        `CHK(irq, ~i[0])
        rd(ser_pkg::OFS_FLAGS);
        `CHK(d, 32'h1 << i)
        rd(ser_pkg::OFS_IRQ_STAT);
        `CHK(d, 32'h1 << i)
        rd(ser_pkg::OFS_IRQ_STAT);
        `CHK(d, 32'h0)
        cyc(2);
        `CHK(irq, 1'h0)
        flt <= '0;
        cyc(4);
        `CHK(`RX, rx(0))
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #1ms;
        n_mismatch++;
        summarize();
    end
    initial begin
        cyc(2);
        aresetn <= 1'h1;
        cyc(1);
        rd(ser_pkg::OFS_DIAG_SEL);
        `CHK(d, 32'h2)
        rd(ser_pkg::OFS_REACTION);
        `CHK(d, 32'h3)
        rd(8'h18);
        `CHK({r, d}, {2'h2, 32'h0})
        wr(8'h18, 32'h1);
        `CHK(r, 2'h2)
        // Even channels raise the interrupt, odd ones stay masked
        wr(ser_pkg::OFS_IRQ_MASK, 32'h1555);
        for (int i = 0; i < 14; i++) run_ch(i, CLS[i]);
        wr(ser_pkg::OFS_CTRL, 32'h1);
        run_ch(12, 2);
        run_ch(13, 1);
        flt <= 14'h0200;
        cyc(300);
        flt <= '0;
        cyc(1);
        flt <= 14'h0200;
        cyc(350);
        `CHK(`RX, rx(0))
        cyc(60);
        `CHK(`RX, rx(1))
        flt <= 14'h0600;
        cyc(406);
        `CHK(`RX, rx(2))
        flt <= 14'h0601;
        cyc(606);
        `CHK(`RX, rx(3))
        // Enable low freezes reactions and deglitch state
        ce <= 1'h0;
        flt <= '0;
        cyc(10);
        `CHK(`RX, rx(3))
        ce <= 1'h1;
        cyc(4);
        `CHK(`RX, rx(0))
        `CHK({rcnt, dcnt}, {32'd8, 32'd11})
        summarize();
    end
endmodule // tb
